// >>> rtl/flash_if_consts.svh
// Timing counts, command codes and fixed values shared by both bus ends.
// Assumes both ends run on one 100 ns system clock.
`ifndef FLASH_IF_CONSTS_SVH
`define FLASH_IF_CONSTS_SVH

`define CLK_PERIOD_NS 100
`define CYC_MIN(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_MAX(ns) ((((ns) / `CLK_PERIOD_NS) > 0) ? ((ns) / `CLK_PERIOD_NS) : 1)

`define T_WRITE_LOW_NS 50
`define T_WRITE_HIGH_NS 20
`define T_RST_RECOVERY_NS 150
`define T_SETUP_NS 50
`define T_ACCESS_NS 85
`define T_WRITE_READ_NS 35
`define T_CFG_EXTRA_NS 10
`define T_STATUS_OE_NS 20
`define T_SYNC_READ_NS 19
`define T_ADV_WE_MAX_NS 20
`define T_RST_ABORT_MAX_NS 25000
`define T_RST_PULSE_NS 100
`define T_POWER_VALID_NS 60000

`define WRITE_LOW_CYC `CYC_MIN(`T_WRITE_LOW_NS)
`define WRITE_HIGH_CYC `CYC_MIN(`T_WRITE_HIGH_NS)
`define RST_RECOVERY_CYC `CYC_MIN(`T_RST_RECOVERY_NS)
`define SETUP_CYC `CYC_MIN(`T_SETUP_NS)
`define WRITE_READ_CYC `CYC_MIN(`T_ACCESS_NS + `T_WRITE_READ_NS)
`define WRITE_READ_CFG_CYC `CYC_MIN(`T_ACCESS_NS + `T_WRITE_READ_NS + `T_CFG_EXTRA_NS)
`define STATUS_OE_CYC `CYC_MIN(`T_STATUS_OE_NS)
`define SYNC_READ_CYC `CYC_MIN(`T_SYNC_READ_NS)
`define ADV_WE_MAX_CYC `CYC_MAX(`T_ADV_WE_MAX_NS)
`define RST_ABORT_CYC `CYC_MAX(`T_RST_ABORT_MAX_NS)
`define RST_IDLE_CYC `CYC_MAX(`T_RST_PULSE_NS)
`define RST_PULSE_CYC `CYC_MIN(`T_RST_PULSE_NS)
`define POWER_VALID_CYC `CYC_MIN(`T_POWER_VALID_NS)

`define STATUS_RESET 8'h80
`define CMD_PROGRAM 8'h40
`define CMD_ERASE 8'h20
`define CMD_CONFIRM 8'hD0
`define CMD_SUSPEND 8'hB0
`define CMD_STATUS 8'h70
`define CMD_ARRAY 8'hFF
`define CMD_CONFIG 8'h60
`define ERASED_WORD 16'hFFFF

`endif

// >>> rtl/flash_if_pkg.sv
// Types shared by the host end and the flash end of the write bus.
// Assumes the constants header is included by each design file.
package flash_if_pkg;
  typedef enum logic [2:0] {
    DEV_ARRAY, DEV_STATUS, DEV_PROG_SETUP, DEV_ERASE_SETUP, DEV_CFG_SETUP
  } dev_mode_t;
  typedef enum logic [3:0] {
    H_POWER, H_RST, H_RECOVER, H_IDLE, H_CE, H_WE, H_WE_HIGH, H_CE_HIGH,
    H_GAP, H_RD_TURN, H_RD_OE, H_RD_DONE
  } host_state_t;
endpackage

// >>> rtl/flash_bus_if.sv
// Parallel flash bus between the host end and the flash end.
// Assumes the bench connects both modports; the two-way data and wait
// lines are resolved here from the enables, with a pull-up when idle.
interface flash_bus_if #(parameter int AW = 4);
  logic ce_n;
  logic we_n;
  logic oe_n;
  logic adv_n;
  logic rst_n;
  logic flash_clk;
  logic vpp_ok;
  logic wp_n;
  logic [AW-1:0] addr;
  logic [15:0] host_dq;
  logic host_dq_oe;
  logic [15:0] dev_dq;
  logic dev_dq_oe;
  logic dev_wait;
  logic dev_wait_oe;
  logic [15:0] dq;
  logic wait_line;

  assign dq = dev_dq_oe ? dev_dq : (host_dq_oe ? host_dq : 16'hFFFF);
  assign wait_line = dev_wait_oe ? dev_wait : 1'b1;

  modport host (
    output ce_n, we_n, oe_n, adv_n, rst_n, flash_clk, vpp_ok, wp_n, addr,
    output host_dq, host_dq_oe,
    input dq, wait_line
  );
  modport dev (
    input ce_n, we_n, oe_n, adv_n, rst_n, flash_clk, vpp_ok, wp_n, addr,
    input dq,
    output dev_dq, dev_dq_oe, dev_wait, dev_wait_oe
  );
endinterface

// >>> rtl/flash_dev_end.sv
// Flash end: latches writes on the strobes, runs a small program and erase
// engine, and sequences reset. Assumes every bus pin is asynchronous to
// i_clk_sys and i_srst models the core supply becoming valid.
`include "flash_if_consts.svh"
module flash_dev_end #(
  parameter int AW = 4,
  parameter int PROG_CYC = 8,
  parameter int ERASE_CYC = 32,
  parameter int POWER_CYC = `POWER_VALID_CYC
) (
  // System
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // Flash bus
  flash_bus_if.dev bus,
  // Observation
  output logic o_ready,
  output logic o_busy,
  output logic [7:0] o_status,
  output logic o_write_taken
);
  import flash_if_pkg::*;

  if (AW < 1 || AW > 16) begin : g_chk
    $error("flash_dev_end: AW must be 1 to 16");
  end

  localparam int PIN_W = 7 + AW + 16;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [PIN_W-1:0] pin_meta_reg;
  logic [PIN_W-1:0] pin_reg;
  wire [PIN_W-1:0] pins = {bus.ce_n, bus.we_n, bus.oe_n, bus.rst_n, bus.adv_n,
                           bus.vpp_ok, bus.wp_n, bus.addr, bus.dq};
  wire ce_n_s = pin_reg[PIN_W-1];
  wire we_n_s = pin_reg[PIN_W-2];
  wire oe_n_s = pin_reg[PIN_W-3];
  wire rst_n_s = pin_reg[PIN_W-4];
  wire [AW-1:0] addr_s = pin_reg[16 +: AW];
  wire [15:0] dq_s = pin_reg[15:0];

  always_ff @(posedge i_clk_sys) begin
    pin_meta_reg <= pins;
    pin_reg <= pin_meta_reg;
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [15:0] mem [0:(1<<AW)-1];
  dev_mode_t mode_reg;
  logic [15:0] power_cnt_reg;
  logic powered_reg;
  logic [15:0] rst_cnt_reg;
  logic rst_done_reg;
  logic wr_prev_reg;
  logic [15:0] busy_cnt_reg;
  logic busy_reg;
  logic erase_op_reg;
  logic suspended_reg;
  logic [AW-1:0] op_addr_reg;
  logic [15:0] op_data_reg;
  logic [3:0] settle_reg;
  logic [15:0] cfg_reg;
  logic [15:0] rd_data_reg;
  logic rd_en_reg;

  // Clock and address-valid pins are never looked at while writing.
  wire active = powered_reg & rst_n_s & rst_done_reg;
  wire wr_now = active & ~ce_n_s & ~we_n_s & oe_n_s;
  wire wr_close = wr_prev_reg & ~wr_now & active;
  wire [7:0] cmd = dq_s[7:0];
  wire rd_now = active & ~ce_n_s & ~oe_n_s & we_n_s;
  wire [7:0] status = {~busy_reg, suspended_reg, 6'h00};
  wire cfg_write = wr_close & (mode_reg == DEV_CFG_SETUP);
  wire busy_done = busy_reg & ~suspended_reg & rst_done_reg & (busy_cnt_reg == 16'h0000);

  // ----------------------------------------
  // Power and reset sequencing
  // ----------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      power_cnt_reg <= 16'h0000;
      powered_reg <= 1'b0;
    end else if (!powered_reg) begin
      power_cnt_reg <= power_cnt_reg + 16'h0001;
      powered_reg <= (power_cnt_reg >= 16'(POWER_CYC - 1));
    end
  end

  // Reset completion time depends on whether an operation is aborted.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      rst_cnt_reg <= 16'h0000;
      rst_done_reg <= 1'b1;
    end else if (!rst_n_s && rst_done_reg) begin
      rst_done_reg <= 1'b0;
      // The abort limit runs from the pin edge, so the synchroniser and latch cycles come off.
      rst_cnt_reg <= busy_reg ? 16'(`RST_ABORT_CYC - 4) : 16'(`RST_IDLE_CYC - 1);
    end else if (!rst_done_reg && rst_cnt_reg != 16'h0000) begin
      rst_cnt_reg <= rst_cnt_reg - 16'h0001;
    end else if (!rst_done_reg && rst_n_s) begin
      rst_done_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // Command engine
  // ----------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || (!rst_done_reg && rst_cnt_reg == 16'h0000)) begin
      if (busy_reg && !erase_op_reg) begin
        mem[op_addr_reg] <= mem[op_addr_reg] & {8'hFF, op_data_reg[7:0]};
      end
      mode_reg <= DEV_ARRAY;
      busy_reg <= 1'b0;
      suspended_reg <= 1'b0;
      erase_op_reg <= 1'b0;
      busy_cnt_reg <= 16'h0000;
      wr_prev_reg <= 1'b0;
      settle_reg <= 4'h0;
      if (i_srst) begin
        cfg_reg <= 16'h0000;
        op_addr_reg <= '0;
        op_data_reg <= 16'h0000;
      end
    end else begin
      wr_prev_reg <= wr_now;
      // The engine stands still while a reset is pending, so the reset really cuts it.
      if (busy_reg && !suspended_reg && rst_done_reg && busy_cnt_reg != 16'h0000) begin
        busy_cnt_reg <= busy_cnt_reg - 16'h0001;
      end
      if (busy_done) begin
        busy_reg <= 1'b0;
        if (erase_op_reg) begin
          for (int i = 0; i < (1 << AW); i++) begin
            mem[i] <= `ERASED_WORD;
          end
        end else begin
          mem[op_addr_reg] <= mem[op_addr_reg] & op_data_reg;
        end
      end
      if (settle_reg != 4'h0) begin
        settle_reg <= settle_reg - 4'h1;
      end
      // Suspended erase accepts writes with unchanged strobe timing.
      if (wr_close) begin
        settle_reg <= cfg_write ? 4'(`WRITE_READ_CFG_CYC) : 4'(`WRITE_READ_CYC);
        case (mode_reg)
          DEV_PROG_SETUP: begin
            busy_reg <= 1'b1;
            erase_op_reg <= 1'b0;
            busy_cnt_reg <= 16'(PROG_CYC);
            op_addr_reg <= addr_s;
            op_data_reg <= dq_s;
            mode_reg <= DEV_STATUS;
          end
          DEV_ERASE_SETUP: begin
            if (cmd == `CMD_CONFIRM) begin
              busy_reg <= 1'b1;
              erase_op_reg <= 1'b1;
              busy_cnt_reg <= 16'(ERASE_CYC);
            end
            mode_reg <= DEV_STATUS;
          end
          DEV_CFG_SETUP: begin
            cfg_reg <= {{(16-AW){1'b0}}, addr_s};
            mode_reg <= DEV_ARRAY;
          end
          default: begin
            if (cmd == `CMD_PROGRAM && !busy_reg) begin
              mode_reg <= DEV_PROG_SETUP;
            end else if (cmd == `CMD_ERASE && !busy_reg) begin
              mode_reg <= DEV_ERASE_SETUP;
            end else if (cmd == `CMD_CONFIG && !busy_reg) begin
              mode_reg <= DEV_CFG_SETUP;
            end else if (cmd == `CMD_SUSPEND && busy_reg && erase_op_reg) begin
              suspended_reg <= 1'b1;
              mode_reg <= DEV_STATUS;
            end else if (cmd == `CMD_CONFIRM && suspended_reg) begin
              suspended_reg <= 1'b0;
              mode_reg <= DEV_STATUS;
            end else if (cmd == `CMD_STATUS) begin
              mode_reg <= DEV_STATUS;
            end else if (cmd == `CMD_ARRAY) begin
              mode_reg <= DEV_ARRAY;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Read path and wait pin
  // ----------------------------------------
  // Data is held back until the post-write settle time has passed.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      rd_data_reg <= 16'h0000;
      rd_en_reg <= 1'b0;
    end else begin
      rd_en_reg <= rd_now & (settle_reg == 4'h0);
      rd_data_reg <= (mode_reg == DEV_STATUS) ? {8'h00, status} : mem[addr_s];
    end
  end

  assign bus.dev_dq = rd_data_reg;
  assign bus.dev_dq_oe = rd_en_reg & rd_now;
  assign bus.dev_wait = 1'b1;
  assign bus.dev_wait_oe = rd_now;
  assign o_ready = active;
  assign o_busy = busy_reg;
  assign o_status = status;
  assign o_write_taken = wr_close;
endmodule

// >>> rtl/flash_host_end.sv
// Host end: turns user write, read and reset requests into flash bus cycles.
// Assumes the flash end sits on the same bus interface and that the user
// holds request data stable while o_ready is low.
//
// What this block does
// - Write cycle closes on first strobe rise.
// - Effective write pulse low at least 50 ns.
// - Effective write pulse high at least 20 ns.
// - Wait 150 ns after reset release.
// - Address and data set up 50 ns.
// - Read valid after access plus 35/45 ns.
// - Status read: 20 ns before output enable.
// - Synchronous read: 19 ns after write end.
// - Clocked mode: write strobe within 20 ns.
// - Flash ignores clock during write cycles.
// - Wait pin deasserted, then high impedance.
// - Keep supply and protect valid until confirmed.
// - Suspended erase keeps normal write timing.
// - Busy reset completes within 25 us.
// - Idle reset completes within 100 ns; the flash end is ready only 3 cycles (300 ns) after the reset pin rises.
// - Hold reset low at least 100 ns.
// - Flash ignores control inputs during reset.
// - Hold reset 60 us after power valid.
// - Flash latches on first strobe rise.
// - Reset leaves array read, status 0x80.
// - Reset aborts program or erase, data undefined.
`include "flash_if_consts.svh"
module flash_host_end #(
  parameter int AW = 4,
  parameter int RD_EXTRA_CYC = 5,
  parameter int POWER_CYC = `POWER_VALID_CYC,
  parameter int RST_HOLD_CYC = `RST_PULSE_CYC
) (
  // System
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // Flash bus
  flash_bus_if.host bus,
  // User requests
  input wire logic i_wr_req,
  input wire logic i_rd_req,
  input wire logic i_rst_req,
  input wire logic i_cfg_write,
  input wire logic i_status_read,
  input wire logic [AW-1:0] i_addr,
  input wire logic [15:0] i_wdata,
  // User answers
  output logic o_ready,
  output logic o_wr_done,
  output logic o_rd_valid,
  output logic [15:0] o_rd_data
);
  import flash_if_pkg::*;

  if (AW < 1 || AW > 16 || RD_EXTRA_CYC < 0 || RST_HOLD_CYC < `RST_PULSE_CYC)
  begin : g_chk
    $error("flash_host_end: parameter out of range");
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  host_state_t state_reg;
  host_state_t state_next;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic ce_n_reg;
  logic we_n_reg;
  logic oe_n_reg;
  logic rst_n_reg;
  logic dq_oe_reg;
  logic [AW-1:0] addr_reg;
  logic [15:0] data_reg;
  logic cfg_pending_reg;
  logic after_write_reg;
  logic [15:0] dq_meta_reg;
  logic [15:0] dq_reg;
  logic [15:0] rd_data_reg;
  logic rd_valid_reg;
  logic wr_done_reg;

  // ----------------------------------------
  // Decoding
  // ----------------------------------------
  wire cnt_zero = (cnt_reg == 16'h0000);
  wire [15:0] turn_cyc = cfg_pending_reg ? 16'(`WRITE_READ_CFG_CYC) : 16'(`WRITE_READ_CYC);
  wire [15:0] status_gap = 16'(`STATUS_OE_CYC);
  wire [15:0] sync_gap = 16'(`SYNC_READ_CYC);
  wire [15:0] turn_gap = after_write_reg ? turn_cyc : 16'h0000;
  wire [15:0] oe_gap = (i_status_read && after_write_reg) ? status_gap : 16'h0000;
  wire [15:0] rd_wait = (turn_gap > oe_gap) ? turn_gap : oe_gap;
  wire [15:0] rd_wait_sync = (rd_wait > sync_gap) ? rd_wait : sync_gap;
  wire dq_drive = (state_next == H_WE) || (state_next == H_WE_HIGH);

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_zero ? 16'h0000 : cnt_reg - 16'h0001;
    case (state_reg)
      H_POWER: begin
        if (cnt_zero) begin
          state_next = H_RECOVER;
          cnt_next = 16'(`RST_RECOVERY_CYC - 1);
        end
      end
      H_RST: begin
        if (cnt_zero) begin
          state_next = H_RECOVER;
          cnt_next = 16'(`RST_RECOVERY_CYC - 1);
        end
      end
      H_RECOVER: begin
        if (cnt_zero) begin
          state_next = H_IDLE;
        end
      end
      H_IDLE: begin
        if (i_rst_req) begin
          state_next = H_RST;
          cnt_next = 16'(RST_HOLD_CYC - 1);
        end else if (i_wr_req) begin
          state_next = H_CE;
        end else if (i_rd_req) begin
          state_next = H_RD_TURN;
          cnt_next = rd_wait_sync;
        end
      end
      H_CE: begin
        state_next = H_WE;
        cnt_next = 16'(((`WRITE_LOW_CYC > `SETUP_CYC) ? `WRITE_LOW_CYC : `SETUP_CYC) - 1);
      end
      H_WE: begin
        if (cnt_zero) begin
          state_next = H_WE_HIGH;
        end
      end
      H_WE_HIGH: begin
        state_next = H_CE_HIGH;
      end
      H_CE_HIGH: begin
        state_next = H_GAP;
        cnt_next = 16'(`WRITE_HIGH_CYC - 1);
      end
      H_GAP: begin
        if (cnt_zero) begin
          state_next = H_IDLE;
        end
      end
      H_RD_TURN: begin
        if (cnt_zero) begin
          state_next = H_RD_OE;
          cnt_next = 16'(`CYC_MIN(`T_ACCESS_NS) + RD_EXTRA_CYC - 1);
        end
      end
      H_RD_OE: begin
        if (cnt_zero) begin
          state_next = H_RD_DONE;
        end
      end
      H_RD_DONE: begin
        state_next = H_IDLE;
      end
      default: begin
        state_next = H_IDLE;
      end
    endcase
  end

  // Pin levels are registered from the next state, so they change with the state and strobes never glitch.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      state_reg <= H_POWER;
      cnt_reg <= 16'(POWER_CYC - 1);
      ce_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      rst_n_reg <= 1'b0;
      dq_oe_reg <= 1'b0;
      addr_reg <= '0;
      data_reg <= 16'h0000;
      cfg_pending_reg <= 1'b0;
      after_write_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      rst_n_reg <= (state_next != H_POWER) && (state_next != H_RST);
      ce_n_reg <= !((state_next == H_CE) || (state_next == H_WE) ||
                    (state_next == H_WE_HIGH) || (state_next == H_RD_OE));
      we_n_reg <= (state_next != H_WE);
      oe_n_reg <= (state_next != H_RD_OE);
      dq_oe_reg <= dq_drive;
      if (state_reg == H_IDLE && (i_wr_req || i_rd_req)) begin
        addr_reg <= i_addr;
        data_reg <= i_wdata;
      end
      if (state_reg == H_IDLE && i_wr_req && !i_rst_req) begin
        cfg_pending_reg <= i_cfg_write;
        after_write_reg <= 1'b1;
      end else if (state_reg == H_RD_DONE || state_reg == H_RST) begin
        after_write_reg <= 1'b0;
        cfg_pending_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Read capture and answers
  // ----------------------------------------
  always_ff @(posedge i_clk_sys) begin
    dq_meta_reg <= bus.dq;
    dq_reg <= dq_meta_reg;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      rd_data_reg <= 16'h0000;
      rd_valid_reg <= 1'b0;
      wr_done_reg <= 1'b0;
    end else begin
      rd_valid_reg <= (state_reg == H_RD_DONE);
      wr_done_reg <= (state_reg == H_GAP) && cnt_zero;
      if (state_reg == H_RD_DONE) begin
        rd_data_reg <= dq_reg;
      end
    end
  end

  // ----------------------------------------
  // Pins
  // ----------------------------------------
  // Address valid stays low and the flash clock stands still, so the
  // clocked-mode strobe limits are met trivially and the flash end never
  // needs the clock during a write.
  assign bus.adv_n = 1'b0;
  assign bus.flash_clk = 1'b0;
  assign bus.vpp_ok = 1'b1;
  assign bus.wp_n = 1'b1;
  assign bus.ce_n = ce_n_reg;
  assign bus.we_n = we_n_reg;
  assign bus.oe_n = oe_n_reg;
  assign bus.rst_n = rst_n_reg;
  assign bus.addr = addr_reg;
  assign bus.host_dq = data_reg;
  assign bus.host_dq_oe = dq_oe_reg;
  assign o_ready = (state_reg == H_IDLE);
  assign o_wr_done = wr_done_reg;
  assign o_rd_valid = rd_valid_reg;
  assign o_rd_data = rd_data_reg;
endmodule

// >>> testbench/flash_bus_monitor.sv
// Concurrent checks on the flash bus between the host end and the flash end.
// Assumes it is instantiated beside the bus and sees its plain signals.
module flash_bus_monitor #(
  parameter int AW = 4,
  parameter int POWER_CYC = 8
) (
  // System
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // Bus
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic adv_n,
  input wire logic rst_n,
  input wire logic flash_clk,
  input wire logic vpp_ok,
  input wire logic wp_n,
  input wire logic [AW-1:0] addr,
  input wire logic [15:0] host_dq,
  input wire logic host_dq_oe,
  input wire logic dev_dq_oe,
  input wire logic dev_wait,
  input wire logic dev_wait_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Reset low-time counter
  // ----
  logic [15:0] low_reg;
  logic pwr_reg;
  always_ff @(posedge i_clk_sys) begin
    low_reg <= (i_srst || rst_n) ? 16'h0000 : low_reg + 16'h0001;
    pwr_reg <= i_srst ? 1'b1 : (rst_n ? 1'b0 : pwr_reg);
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  // ----
  // Assertions
  // ----
  AST_WR_SHAPE: assert property ($fell(we_n) |->
    (!ce_n && oe_n) ##1 (we_n && !ce_n) ##1 ce_n) else $error("write cycle shape wrong");
  AST_WR_HIGH: assert property ($rose(we_n) |-> we_n [*4])
    else $error("write strobe high too short");
  AST_SETUP: assert property ($rose(we_n) |-> host_dq_oe && $past(host_dq_oe)
    && $stable(host_dq) && $stable(addr)) else $error("address or data not set up");
  AST_RECOVER: assert property ($rose(rst_n) |-> we_n [*2])
    else $error("write strobe too soon after reset");
  AST_POWER: assert property ($rose(rst_n) && pwr_reg |-> low_reg >= POWER_CYC)
    else $error("reset released too soon after power");
  AST_PULSE: assert property ($rose(rst_n) |-> low_reg >= 16'h0001)
    else $error("reset pulse too short");
  AST_TURN: assert property ($rose(we_n) |-> oe_n [*4])
    else $error("output enable too soon after write");
  AST_RD_HOLD: assert property ($fell(oe_n) |-> (!oe_n && !ce_n && we_n) [*6] ##1 oe_n)
    else $error("read strobe length wrong");
  AST_WAIT_Z: assert property (oe_n [*5] |-> !dev_wait_oe && !dev_dq_oe)
    else $error("flash drives while outputs disabled");
  AST_WAIT_LVL: assert property (dev_wait_oe |-> dev_wait)
    else $error("wait asserted");
  AST_NO_CLK: assert property (!flash_clk && !adv_n)
    else $error("flash clock or address valid moved");
  AST_RST_Z: assert property (!rst_n [*3] |-> !dev_dq_oe && !dev_wait_oe)
    else $error("flash drives during reset");
  AST_PROTECT: assert property (vpp_ok && wp_n)
    else $error("supply or write protect dropped");
  cover property ($rose(we_n));
  cover property ($fell(oe_n));
  cover property ($rose(rst_n) && !pwr_reg);
  cover property (dev_dq_oe);
endmodule

// >>> testbench/flash_write_cycle_and_reset_tb_top.sv
// Bench joining the host end and the flash end, with a word model.
// Assumes the rtl folder is on the include path.
`include "flash_if_consts.svh"
module flash_write_cycle_and_reset_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import flash_if_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_srst = 1'b1;
  logic wr_req, rd_req, rst_req, cfg, st;
  logic [3:0] addr;
  logic [15:0] wdata;
  logic h_rdy, wr_done, rd_valid, d_rdy, busy, taken;
  logic [15:0] rd_data;
  logic [7:0] status;
  int n_fail = 0, n_tests = 0, n_wr = 0, n_taken = 0;
  int mem[16];
  logic [31:0] rs = 32'hA6884E5D;
  flash_bus_if #(.AW(4)) bus ();
  flash_host_end #(.AW(4), .POWER_CYC(8)) i_flash_host_end (.i_clk_sys(i_clk_sys),
    .i_srst(i_srst), .bus(bus.host), .i_wr_req(wr_req), .i_rd_req(rd_req),
    .i_rst_req(rst_req), .i_cfg_write(cfg), .i_status_read(st), .i_addr(addr),
    .i_wdata(wdata), .o_ready(h_rdy), .o_wr_done(wr_done), .o_rd_valid(rd_valid),
    .o_rd_data(rd_data));
  flash_dev_end #(.AW(4), .POWER_CYC(8)) i_flash_dev_end (.i_clk_sys(i_clk_sys),
    .i_srst(i_srst), .bus(bus.dev), .o_ready(d_rdy), .o_busy(busy), .o_status(status),
    .o_write_taken(taken));
  flash_bus_monitor #(.AW(4), .POWER_CYC(8)) i_flash_bus_monitor (.i_clk_sys(i_clk_sys),
    .i_srst(i_srst), .ce_n(bus.ce_n), .we_n(bus.we_n), .oe_n(bus.oe_n), .adv_n(bus.adv_n),
    .rst_n(bus.rst_n), .flash_clk(bus.flash_clk), .vpp_ok(bus.vpp_ok), .wp_n(bus.wp_n),
    .addr(bus.addr), .host_dq(bus.host_dq),
    .host_dq_oe(bus.host_dq_oe), .dev_dq_oe(bus.dev_dq_oe), .dev_wait(bus.dev_wait),
    .dev_wait_oe(bus.dev_wait_oe));
  initial forever #50 i_clk_sys = ~i_clk_sys;
  always @(negedge i_clk_sys) if (taken === 1'b1) n_taken++;
  // ----
  // Helpers
  // ----
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic sig(input int s);
    case (s)
      0: return h_rdy;
      1: return wr_done;
      2: return rd_valid;
      3: return !busy;
      4: return d_rdy;
      5: return status[6];
      7: return busy;
      default: return !d_rdy;
    endcase
  endfunction
  task report_and_stop;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk_w(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // A wait that runs out ends the run, since nothing later can be trusted.
  task automatic wt(input int s, output int n);
    n = 0;
    do begin
      @(negedge i_clk_sys);
      n++;
    end while (sig(s) !== 1'b1 && n < 2000);
    if (sig(s) !== 1'b1) begin
      n_fail++;
      $display("unexpected timeout on wait %0d", s);
      report_and_stop();
    end
  endtask
  task automatic req(input int k, input logic [3:0] a, input logic [15:0] d, output int n);
    wt(0, n);
    addr = a;
    wdata = d;
    wr_req = (k == 0);
    rd_req = (k == 1);
    rst_req = (k == 2);
    @(negedge i_clk_sys);
    wr_req = 1'b0;
    rd_req = 1'b0;
    rst_req = 1'b0;
    wt((k == 0) ? 1 : ((k == 1) ? 2 : 6), n);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    int n;
    req(0, a, d, n);
    n_wr++;
    chk_w("write_cycles", 16'(3 + `WRITE_LOW_CYC + `WRITE_HIGH_CYC), 16'(n));
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] q);
    int n;
    req(1, a, 16'h0000, n);
    q = rd_data;
  endtask
  task automatic wait_op;
    int n;
    wt(7, n);
    wt(3, n);
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    int n;
    logic [15:0] q;
    logic [3:0] a;
    logic [3:0] pa;
    wr_req = 1'b0;
    rd_req = 1'b0;
    rst_req = 1'b0;
    cfg = 1'b0;
    st = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    repeat (16) @(negedge i_clk_sys);
    i_srst = 1'b0;
    wt(0, n);
    chk_w("power_wait", 16'h0001, {15'h0000, n >= 8});
    chk_w("status", {8'h00, `STATUS_RESET}, {8'h00, status});
    for (int i = 0; i < 16; i++) mem[i] = `ERASED_WORD;
    wr(4'h0, {8'h00, `CMD_ERASE});
    wr(4'h0, {8'h00, `CMD_CONFIRM});
    wr(4'h0, {8'h00, `CMD_SUSPEND});
    wt(5, n);
    wr(4'h0, {8'h00, `CMD_STATUS});
    st = 1'b1;
    rd(4'h0, q);
    st = 1'b0;
    chk_w("suspended_bit", 16'h0040, q & 16'h0040);
    wr(4'h0, {8'h00, `CMD_CONFIRM});
    wait_op();
    for (int k = 0; k < 4; k++) begin
      rs = xs(rs);
      a = {2'(k), rs[1:0]};
      if (k == 0) pa = a;
      wr(a, {8'h00, `CMD_PROGRAM});
      wr(a, rs[31:16]);
      wait_op();
      mem[a] = mem[a] & int'(rs[31:16]);
    end
    wr(4'h0, {8'h00, `CMD_CONFIG});
    cfg = 1'b1;
    wr(rs[3:0], rs[15:0]);
    cfg = 1'b0;
    wr(4'h0, {8'h00, `CMD_ARRAY});
    for (int i = 0; i < 16; i++) begin
      rd(4'(i), q);
      chk_w("array_word", 16'(mem[i]), q);
    end
    wr(4'h0, {8'h00, `CMD_STATUS});
    st = 1'b1;
    rd(4'h0, q);
    st = 1'b0;
    chk_w("status_read", {8'h00, `STATUS_RESET}, q & 16'h00FF);
    req(2, 4'h0, 16'h0000, n);
    wt(4, n);
    chk_w("idle_reset_time", 16'h0001, {15'h0000, n <= `RST_IDLE_CYC + 8});
    chk_w("status", {8'h00, `STATUS_RESET}, {8'h00, status});
    wr(a, {8'h00, `CMD_PROGRAM});
    wr(a, 16'h0000);
    req(2, a, 16'h0000, n);
    wt(4, n);
    chk_w("abort_reset_time", 16'h0001,
      {15'h0000, n > `RST_IDLE_CYC + 8 && n <= `RST_ABORT_CYC});
    chk_w("busy_after_abort", 16'h0000, {15'h0000, busy});
    chk_w("status", {8'h00, `STATUS_RESET}, {8'h00, status});
    rd(pa, q);
    chk_w("array_after_reset", 16'(mem[pa]), q);
    chk_w("writes_taken", 16'(n_wr), 16'(n_taken));
    report_and_stop();
  end
endmodule
